// ---- dv/subset_exec_test.sv ----
// Self-checking bench for the instruction subset executor.
// Assumes the design files under hdl/ and exec_defs.svh on the include path.
`include "exec_defs.svh"
module subset_exec_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic SYS_CLK = 1'b0;
  logic NRST = 1'b0;
  logic INSTR_VALID = 1'b0;
  logic WAKE_EVENT = 1'b0;
  logic [3:0] INSTR_OP = 4'h0;
  logic [7:0] INSTR_MEM_ADDR = 8'h00;
  logic [7:0] INSTR_IMM = 8'h00;
  logic [10:0] INSTR_BRANCH_ADDR = 11'h000;
  logic [7:0] MEM_RDATA, MEM_ADDR, MEM_WDATA, WORKING_REGISTER;
  logic INSTR_READY, MEM_WE, ZERO_FLAG, SLEEP_ENTERED_FLAG, WATCHDOG_TIMEOUT_FLAG;
  logic WATCHDOG_CLEAR, CLOCK_GATE_OFF, PC_LOAD;
  logic [10:0] PROGRAM_COUNTER;
  logic [7:0] mem [256];
  logic [7:0] ref_mem [256];
  logic [15:0] mem_q[$];
  logic [25:0] st_q[$];
  logic [7:0] e_w = 8'h00;
  logic e_z = 1'b0;
  logic e_sl = 1'b0;
  logic [10:0] e_pc = 11'h000;
  logic [31:0] seed = 32'h638DF6EC;
  logic acc_d = 1'b0;
  int err_total = 0;
  int cmp_count = 0;
  int cycles = 0;
  wire [25:0] st_now = {WORKING_REGISTER, ZERO_FLAG, SLEEP_ENTERED_FLAG, WATCHDOG_TIMEOUT_FLAG,
    WATCHDOG_CLEAR, CLOCK_GATE_OFF, INSTR_READY, PC_LOAD, PROGRAM_COUNTER};

  subset_exec DUT (.*);

  // The bench stands in for data memory: combinational read, write on the edge.
  assign MEM_RDATA = mem[MEM_ADDR];
  always @(posedge SYS_CLK) if (MEM_WE) mem[MEM_ADDR] <= MEM_WDATA;
  always #4 SYS_CLK = ~SYS_CLK;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask

  task automatic cmp_state(input logic [25:0] e);
    check("state", {6'h00, e}, {6'h00, st_now});
  endtask

  task automatic cmp_mem(input logic [15:0] e);
    check("memory write", {16'h0000, e}, {16'h0000, MEM_ADDR, MEM_WDATA});
  endtask

  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Watcher: writes in the accept cycle, state in the cycle after it.
  // ----------------------------------------------------------------
  always @(negedge SYS_CLK) begin
    if (NRST && MEM_WE) begin
      if (mem_q.size() == 0) check("stray write", 32'h0, 32'h1);
      else cmp_mem(mem_q.pop_front());
    end
    if (acc_d) cmp_state(st_q.pop_front());
    acc_d = NRST && INSTR_VALID && INSTR_READY;
  end

  always @(posedge SYS_CLK) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_total++;
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // Driver: notes the expectation, then holds the request until taken.
  // ----------------------------------------------------------------
  task automatic issue(input logic [3:0] op, input logic [7:0] a, input logic [7:0] imm,
      input logic [10:0] ba);
    logic [7:0] v;
    logic [7:0] r;
    logic rdy;
    v = ref_mem[a];
    r = (op == `OP_MINUS_ONE_IN_PLACE || op == `OP_MINUS_ONE_TO_WORKING) ? v - 8'h01 : v + 8'h01;
    case (op)
      `OP_MINUS_ONE_IN_PLACE, `OP_PLUS_ONE_IN_PLACE: begin
        ref_mem[a] = r;
        mem_q.push_back({a, r});
        e_z = (r == 8'h00);
      end
      `OP_MINUS_ONE_TO_WORKING, `OP_PLUS_ONE_TO_WORKING: begin
        e_w = r;
        e_z = (r == 8'h00);
      end
      `OP_POWER_DOWN: e_sl = 1'b1;
      `OP_COPY_MEM_TO_WORKING: e_w = v;
      `OP_COPY_IMM_TO_WORKING: e_w = imm;
      `OP_COPY_WORKING_TO_MEM: begin
        ref_mem[a] = e_w;
        mem_q.push_back({a, e_w});
      end
      default: ;
    endcase
    if (op == `OP_UNCONDITIONAL_BRANCH) e_pc = ba;
    else if (op != `OP_POWER_DOWN) e_pc = e_pc + 11'h001;
    st_q.push_back({e_w, e_z, e_sl, 1'b0, {2{op == `OP_POWER_DOWN}},
      !(op == `OP_POWER_DOWN || op == `OP_UNCONDITIONAL_BRANCH),
      op == `OP_UNCONDITIONAL_BRANCH, e_pc});
    INSTR_VALID <= 1'b1;
    INSTR_OP <= op;
    INSTR_MEM_ADDR <= a;
    INSTR_IMM <= imm;
    INSTR_BRANCH_ADDR <= ba;
    do begin
      @(negedge SYS_CLK);
      rdy = INSTR_READY;
      @(posedge SYS_CLK);
    end while (!rdy);
  endtask

  task automatic idle(input int n);
    INSTR_VALID <= 1'b0;
    repeat (n) begin
      INSTR_OP <= rnd() % 16;
      @(posedge SYS_CLK);
    end
  endtask

  // A refused request is held up while asleep; nothing may move.
  task automatic sleep_wake();
    logic [25:0] held;
    int k;
    INSTR_VALID <= 1'b1;
    INSTR_OP <= `OP_PLUS_ONE_IN_PLACE;
    INSTR_MEM_ADDR <= 8'h20;
    repeat (2) @(negedge SYS_CLK);
    held = st_now;
    repeat (10) @(negedge SYS_CLK) cmp_state(held);
    @(posedge SYS_CLK);
    INSTR_VALID <= 1'b0;
    WAKE_EVENT <= 1'b1;
    k = 0;
    do begin
      @(negedge SYS_CLK);
      k++;
    end while (!INSTR_READY && k < 8);
    check("wake latency", 32'h1, {31'h0, k >= 2 && k <= 4});
    cmp_state({held[25:14], 2'b01, held[11:0]});
    @(posedge SYS_CLK);
    WAKE_EVENT <= 1'b0;
  endtask

  initial begin
    logic [3:0] ops [9];
    ops = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9};
    for (int i = 0; i < 256; i++) begin
      mem[i] = rnd();
      ref_mem[i] = mem[i];
    end
    repeat (5) @(posedge SYS_CLK);
    NRST <= 1'b1;
    @(negedge SYS_CLK);
    cmp_state(26'h0001000);
    @(posedge SYS_CLK);
    $display("test reset done");
    foreach (ops[j]) begin
      if (ops[j] >= 4'h1 && ops[j] <= 4'h4) begin
        foreach (ops[t]) begin
          if (t < 3) begin
            issue(`OP_COPY_IMM_TO_WORKING, 8'h00, t == 0 ? 8'h00 : (t == 1 ? 8'h01 : 8'hFF), 0);
            issue(`OP_COPY_WORKING_TO_MEM, 8'h10 + j, 8'h00, 0);
            issue(ops[j], 8'h10 + j, 8'h00, 0);
            issue(`OP_COPY_MEM_TO_WORKING, 8'h10 + j, 8'h00, 0);
          end
        end
      end
    end
    $display("test boundary done");
    issue(`OP_UNCONDITIONAL_BRANCH, 8'h00, 8'h00, 11'h7FF);
    issue(`OP_PLUS_ONE_IN_PLACE, 8'h05, 8'h00, 0);
    issue(`OP_UNCONDITIONAL_BRANCH, 8'h00, 8'h00, 11'h000);
    issue(`OP_UNCONDITIONAL_BRANCH, 8'h00, 8'h00, rnd());
    issue(`OP_NOP, 8'h00, 8'h00, 0);
    $display("test branch done");
    issue(`OP_COPY_IMM_TO_WORKING, 8'h00, 8'hA5, 0);
    issue(`OP_POWER_DOWN, 8'h00, 8'h00, 0);
    sleep_wake();
    issue(`OP_COPY_WORKING_TO_MEM, 8'h21, 8'h00, 0);
    $display("test power-down done");
    repeat (200) begin
      issue(ops[rnd() % 9], rnd() % 16, rnd(), rnd());
      if (rnd() % 4 == 0) idle(1 + rnd() % 3);
    end
    idle(4);
    check("pending notes", 32'h0, mem_q.size() + st_q.size());
    $display("test random done");
    test_done();
  end
endmodule

// ---- hdl/exec_defs.svh ----
// Constants for the instruction subset executor: opcodes, reset values, timing.
// Assumes it is included by bare name from the package and design files.
`ifndef EXEC_DEFS_SVH
`define EXEC_DEFS_SVH
// ----------------------------------------------------------------
// Operation codes
// ----------------------------------------------------------------
`define OP_NOP 4'h0
`define OP_MINUS_ONE_IN_PLACE 4'h1
`define OP_MINUS_ONE_TO_WORKING 4'h2
`define OP_PLUS_ONE_IN_PLACE 4'h3
`define OP_PLUS_ONE_TO_WORKING 4'h4
`define OP_POWER_DOWN 4'h5
`define OP_UNCONDITIONAL_BRANCH 4'h6
`define OP_COPY_MEM_TO_WORKING 4'h7
`define OP_COPY_IMM_TO_WORKING 4'h8
`define OP_COPY_WORKING_TO_MEM 4'h9
// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define WORKING_RST 8'h00
`define PC_RST 11'h000
`define BRANCH_CYCLES 2
`endif

// ---- hdl/exec_pkg.sv ----
// Types shared by the instruction subset executor.
// Assumes exec_defs.svh is on the include path.
`include "exec_defs.svh"
package exec_pkg;
  typedef enum logic [1:0] {ST_RUN, ST_BRANCH_DUMMY, ST_SLEEP} exec_state_t;
endpackage

// ---- hdl/step_unit.sv ----
// Increment and decrement unit with zero detection.
// Assumes a purely combinational use by the executor.
module step_unit #(
  parameter int WIDTH = 8
) (
  input wire logic [WIDTH-1:0] operand,
  input wire logic minus,
  output logic [WIDTH-1:0] result,
  output logic zero
);
  initial begin
    if (WIDTH < 1) begin
      $error("step_unit width must be at least one");
    end
  end
  // Natural truncation to WIDTH gives the wrap: all-ones plus one is zero.
  always_comb begin
    if (minus) begin
      result = operand - WIDTH'(1);
    end else begin
      result = operand + WIDTH'(1);
    end
    zero = (result == '0);
  end
endmodule

// ---- hdl/subset_exec.sv ----
// Executor for a subset of an 8-bit core: step, copy, branch and power-down.
// Assumes the fetch stage presents one decoded instruction per valid cycle and
// that data memory answers reads combinationally in the same cycle.
//
// Local design decisions: the placing of the registers and the plain strobed port.
`include "exec_defs.svh"
module subset_exec
  import exec_pkg::*;
#(
  parameter int DATA_W = 8,
  parameter int ADDR_W = 8,
  parameter int PC_W = 11
) (
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic INSTR_VALID,
  input wire logic [3:0] INSTR_OP,
  input wire logic [ADDR_W-1:0] INSTR_MEM_ADDR,
  input wire logic [DATA_W-1:0] INSTR_IMM,
  input wire logic [PC_W-1:0] INSTR_BRANCH_ADDR,
  input wire logic [DATA_W-1:0] MEM_RDATA,
  input wire logic WAKE_EVENT,
  output logic INSTR_READY,
  output logic [ADDR_W-1:0] MEM_ADDR,
  output logic MEM_WE,
  output logic [DATA_W-1:0] MEM_WDATA,
  output logic [DATA_W-1:0] WORKING_REGISTER,
  output logic ZERO_FLAG,
  output logic SLEEP_ENTERED_FLAG,
  output logic WATCHDOG_TIMEOUT_FLAG,
  output logic WATCHDOG_CLEAR,
  output logic CLOCK_GATE_OFF,
  output logic [PC_W-1:0] PROGRAM_COUNTER,
  output logic PC_LOAD
);
  initial begin
    if (DATA_W != 8) begin
      $error("subset_exec serves an 8-bit data path only");
    end
    if (ADDR_W < 1 || PC_W < 1) begin
      $error("subset_exec address widths must be positive");
    end
  end

  // ----------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------
  // A function because several assertions need the same step decode.
  function automatic logic is_step(input logic [3:0] op);
    is_step = (op == `OP_MINUS_ONE_IN_PLACE) || (op == `OP_MINUS_ONE_TO_WORKING) ||
              (op == `OP_PLUS_ONE_IN_PLACE) || (op == `OP_PLUS_ONE_TO_WORKING);
  endfunction

  exec_state_t state_r, state_nxt;
  logic [DATA_W-1:0] working_r, working_nxt;
  logic zero_r, zero_nxt;
  logic sleep_r, sleep_nxt;
  logic timeout_r, timeout_nxt;
  logic [PC_W-1:0] pc_r, pc_nxt;
  logic pc_load_r, pc_load_nxt;
  logic wdog_clr_r, wdog_clr_nxt;
  logic wake_s1_r, wake_s2_r;
  logic accept;
  logic minus;
  logic [DATA_W-1:0] step_res;
  logic step_zero;

  assign accept = INSTR_VALID && (state_r == ST_RUN);
  assign minus = (INSTR_OP == `OP_MINUS_ONE_IN_PLACE) ||
                 (INSTR_OP == `OP_MINUS_ONE_TO_WORKING);

  step_unit #(.WIDTH(DATA_W)) u_step (
    .operand(MEM_RDATA),
    .minus(minus),
    .result(step_res),
    .zero(step_zero)
  );

  // ----------------------------------------------------------------
  // Wake-up synchroniser
  // ----------------------------------------------------------------
  // The wake source lives outside the gated clock, so it is synchronised first.
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      wake_s1_r <= 1'b0;
      wake_s2_r <= 1'b0;
    end else begin
      wake_s1_r <= WAKE_EVENT;
      wake_s2_r <= wake_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // Memory port
  // ----------------------------------------------------------------
  // Memory writes are combinational with the accepted instruction so the
  // read-modify-write completes in one cycle.
  always_comb begin
    MEM_ADDR = INSTR_MEM_ADDR;
    MEM_WE = 1'b0;
    MEM_WDATA = step_res;
    if (accept) begin
      case (INSTR_OP)
        `OP_MINUS_ONE_IN_PLACE: MEM_WE = 1'b1;
        `OP_PLUS_ONE_IN_PLACE: MEM_WE = 1'b1;
        `OP_COPY_WORKING_TO_MEM: begin
          MEM_WE = 1'b1;
          MEM_WDATA = working_r;
        end
        default: MEM_WE = 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Execution state
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    working_nxt = working_r;
    zero_nxt = zero_r;
    sleep_nxt = sleep_r;
    timeout_nxt = timeout_r;
    pc_nxt = pc_r;
    pc_load_nxt = 1'b0;
    wdog_clr_nxt = 1'b0;
    case (state_r)
      ST_RUN: begin
        if (INSTR_VALID) begin
          case (INSTR_OP)
            `OP_MINUS_ONE_IN_PLACE: zero_nxt = step_zero;
            `OP_PLUS_ONE_IN_PLACE: zero_nxt = step_zero;
            `OP_MINUS_ONE_TO_WORKING: begin
              working_nxt = step_res;
              zero_nxt = step_zero;
            end
            `OP_PLUS_ONE_TO_WORKING: begin
              working_nxt = step_res;
              zero_nxt = step_zero;
            end
            `OP_COPY_MEM_TO_WORKING: working_nxt = MEM_RDATA;
            `OP_COPY_IMM_TO_WORKING: working_nxt = INSTR_IMM;
            `OP_UNCONDITIONAL_BRANCH: begin
              pc_nxt = INSTR_BRANCH_ADDR;
              pc_load_nxt = 1'b1;
              state_nxt = ST_BRANCH_DUMMY;
            end
            `OP_POWER_DOWN: begin
              sleep_nxt = 1'b1;
              timeout_nxt = 1'b0;
              wdog_clr_nxt = 1'b1;
              state_nxt = ST_SLEEP;
            end
            default: pc_nxt = pc_r + PC_W'(1);
          endcase
          if (INSTR_OP != `OP_UNCONDITIONAL_BRANCH && INSTR_OP != `OP_POWER_DOWN) begin
            pc_nxt = pc_r + PC_W'(1);
          end
        end
      end
      // The slot after a branch runs as a dummy; nothing architectural moves.
      ST_BRANCH_DUMMY: state_nxt = ST_RUN;
      // Everything holds while asleep; only a wake event leaves.
      ST_SLEEP: begin
        if (wake_s2_r) begin
          state_nxt = ST_RUN;
        end
      end
      default: state_nxt = ST_RUN;
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      state_r <= ST_RUN;
      working_r <= `WORKING_RST;
      zero_r <= 1'b0;
      sleep_r <= 1'b0;
      timeout_r <= 1'b0;
      pc_r <= `PC_RST;
      pc_load_r <= 1'b0;
      wdog_clr_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      working_r <= working_nxt;
      zero_r <= zero_nxt;
      sleep_r <= sleep_nxt;
      timeout_r <= timeout_nxt;
      pc_r <= pc_nxt;
      pc_load_r <= pc_load_nxt;
      wdog_clr_r <= wdog_clr_nxt;
    end
  end

  assign INSTR_READY = (state_r == ST_RUN);
  assign WORKING_REGISTER = working_r;
  assign ZERO_FLAG = zero_r;
  assign SLEEP_ENTERED_FLAG = sleep_r;
  assign WATCHDOG_TIMEOUT_FLAG = timeout_r;
  assign WATCHDOG_CLEAR = wdog_clr_r;
  assign CLOCK_GATE_OFF = (state_r == ST_SLEEP);
  assign PROGRAM_COUNTER = pc_r;
  assign PC_LOAD = pc_load_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_minus_mem_write: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    accept && INSTR_OP == `OP_MINUS_ONE_IN_PLACE |->
      MEM_WE && MEM_WDATA == DATA_W'(MEM_RDATA - 8'h01) ##1
      zero_r == ($past(MEM_WDATA) == 8'h00) && $stable(working_r))
    else $error("in-place decrement wrong");
  a_minus_to_working: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    accept && INSTR_OP == `OP_MINUS_ONE_TO_WORKING |->
      !MEM_WE ##1 working_r == DATA_W'($past(MEM_RDATA) - 8'h01))
    else $error("decrement to working wrong");
  a_inc_mem_write: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    accept && INSTR_OP == `OP_PLUS_ONE_IN_PLACE |->
      MEM_WE && MEM_WDATA == DATA_W'(MEM_RDATA + 8'h01) ##1 $stable(working_r))
    else $error("in-place increment wrong");
  a_inc_to_working: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    accept && INSTR_OP == `OP_PLUS_ONE_TO_WORKING |->
      !MEM_WE ##1 working_r == DATA_W'($past(MEM_RDATA) + 8'h01))
    else $error("increment to working wrong");
  a_sleep_gates_clock: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    accept && INSTR_OP == `OP_POWER_DOWN |=> CLOCK_GATE_OFF && !INSTR_READY)
    else $error("power-down did not gate clock");
  a_sleep_holds_state: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    state_r == ST_SLEEP |-> !MEM_WE ##1 $stable(working_r) && $stable(pc_r) && $stable(zero_r))
    else $error("state changed while asleep");
  a_sleep_clears_wdog: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    accept && INSTR_OP == `OP_POWER_DOWN |=> WATCHDOG_CLEAR)
    else $error("watchdog not cleared");
  a_sleep_flags: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    accept && INSTR_OP == `OP_POWER_DOWN |=>
      SLEEP_ENTERED_FLAG && !WATCHDOG_TIMEOUT_FLAG && $stable(zero_r))
    else $error("power-down flags wrong");
  a_branch_two_cycles: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    accept && INSTR_OP == `OP_UNCONDITIONAL_BRANCH |=>
      PC_LOAD && pc_r == $past(INSTR_BRANCH_ADDR) && !INSTR_READY ##1 INSTR_READY)
    else $error("branch timing wrong");
  a_copy_no_flags: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    accept && INSTR_OP == `OP_COPY_IMM_TO_WORKING |=>
      working_r == $past(INSTR_IMM) && $stable(zero_r))
    else $error("immediate copy wrong");
  a_store_working: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    accept && INSTR_OP == `OP_COPY_WORKING_TO_MEM |-> MEM_WE && MEM_WDATA == working_r)
    else $error("store of working register wrong");
  a_wrap_inc: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    accept && is_step(INSTR_OP) && !minus && MEM_RDATA == 8'hFF |=> zero_r)
    else $error("increment did not wrap");

  // The zero check rebuilds the step from the memory data, not from the step unit.
  a_step_zero: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    accept && is_step(INSTR_OP) |=>
      zero_r == (DATA_W'($past(MEM_RDATA) + ($past(minus) ? 8'hFF : 8'h01)) == 8'h00))
    else $error("zero flag does not match the step result");
  a_wrap_minus: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    accept && is_step(INSTR_OP) && minus && MEM_RDATA == 8'h00 |-> step_res == 8'hFF)
    else $error("decrement did not wrap");
  a_branch_loads_pc: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    accept && INSTR_OP == `OP_UNCONDITIONAL_BRANCH |->
      !MEM_WE ##1 pc_r == $past(INSTR_BRANCH_ADDR) && $stable(zero_r) && $stable(working_r))
    else $error("branch moved more than the program counter");
  a_dummy_refuses: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    state_r == ST_BRANCH_DUMMY |->
      !MEM_WE && !INSTR_READY ##1 $stable(working_r) && $stable(pc_r) && $stable(zero_r))
    else $error("dummy slot after a branch had an effect");
  a_pc_advance: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    accept && INSTR_OP != `OP_UNCONDITIONAL_BRANCH && INSTR_OP != `OP_POWER_DOWN |=>
      pc_r == PC_W'($past(pc_r) + PC_W'(1)) && !PC_LOAD)
    else $error("program counter did not advance");
  a_copy_from_mem: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    accept && INSTR_OP == `OP_COPY_MEM_TO_WORKING |->
      !MEM_WE ##1 working_r == $past(MEM_RDATA) && $stable(zero_r))
    else $error("memory to working copy wrong");
  a_imm_no_write: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    accept && INSTR_OP == `OP_COPY_IMM_TO_WORKING |-> !MEM_WE)
    else $error("immediate copy wrote memory");
  a_store_flags: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    accept && INSTR_OP == `OP_COPY_WORKING_TO_MEM |=> $stable(zero_r) && $stable(working_r))
    else $error("store of working register changed a flag");
  a_wdog_pulse: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    WATCHDOG_CLEAR |=> !WATCHDOG_CLEAR)
    else $error("watchdog clear longer than one cycle");
  a_gate_only_asleep: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    CLOCK_GATE_OFF |-> !INSTR_READY && !MEM_WE)
    else $error("work accepted while the clock is gated");
  // Wake is judged after its second flip-flop, where the state machine reads it.
  a_wake_leaves_sleep: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    state_r == ST_SLEEP && wake_s2_r |=> INSTR_READY && !CLOCK_GATE_OFF)
    else $error("wake event did not restart execution");
  a_sleep_flag_holds: assert property (@(posedge SYS_CLK) disable iff (!NRST)
    CLOCK_GATE_OFF |-> SLEEP_ENTERED_FLAG && !WATCHDOG_TIMEOUT_FLAG)
    else $error("power-down flags lost while asleep");

  // ----------------------------------------------------------------
  // Cover points
  // ----------------------------------------------------------------
  c_branch: cover property (@(posedge SYS_CLK) accept && INSTR_OP == `OP_UNCONDITIONAL_BRANCH);
  c_sleep_wake: cover property (@(posedge SYS_CLK) state_r == ST_SLEEP ##1 state_r == ST_RUN);
  c_minus_zero: cover property (@(posedge SYS_CLK)
    accept && INSTR_OP == `OP_MINUS_ONE_IN_PLACE && MEM_RDATA == 8'h01);
  c_inc_wrap: cover property (@(posedge SYS_CLK)
    accept && INSTR_OP == `OP_PLUS_ONE_IN_PLACE && MEM_RDATA == 8'hFF);
  c_store: cover property (@(posedge SYS_CLK) accept && INSTR_OP == `OP_COPY_WORKING_TO_MEM);
endmodule
